// *** verilog/dpc_map.svh ***
// Register offsets, field positions, widths and reset values of the profile
// and coefficient store. Assumes a six-bit register address below two subchip bits.
`ifndef DPC_MAP_SVH
`define DPC_MAP_SVH
`define DPC_REG_TRIG 6'h00
`define DPC_TRIG_BIT 2
`define DPC_REG_COEFF_PTR 6'h06
`define DPC_REG_COEFF_DATA 6'h07
`define DPC_REG_PROF_PTR 6'h08
`define DPC_REG_PROF_DATA 6'h09
`define DPC_REG_PROF_SEL 6'h0e
`define DPC_REG_DEC_SHIFT 6'h1d
`define DPC_REG_MAN_START 6'h1f
`define DPC_REG_MAN_FREQ_EN 6'h20
`define DPC_REG_MAN_FREQ 6'h21
`define DPC_SEL_IDX 15:11
`define DPC_PF_PTR 35:28
`define DPC_PF_DEC 27:22
`define DPC_PF_FREQ 21:6
`define DPC_PF_GAIN 4:2
`define DPC_MS_EN 15
`define DPC_MS_START 14:7
`define DPC_MD_EN 6
`define DPC_MD_DEC 5:0
`define DPC_SH_EN 7
`define DPC_SH_GAIN 6:4
`define DPC_MF_EN 0
`define DPC_LEN_REG 7'h10
`define DPC_LEN_PROF 7'h40
`define DPC_LEN_COEFF 7'h70
`define DPC_ADDR_LAST 7'h07
`define DPC_REG_RESET 16'h0000
`endif

// *** verilog/dpc_pkg.sv ***
// Types shared by the profile and coefficient store.
// Assumes dpc_map.svh holds all register numbers.
`default_nettype none
package dpc_pkg;
   typedef struct packed {
      logic [7:0] coeff_start;
      logic [5:0] dec_factor;
      logic [15:0] freq;
      logic [2:0] gain;
   } dpc_cfg_t;
   typedef logic [7:0][13:0] dpc_block_t;
   typedef logic [7:0][7:0] dpc_index_t;
   typedef enum logic [2:0] {
      DPC_IDLE = 3'b001,
      DPC_ADDR = 3'b010,
      DPC_DATA = 3'b100
   } dpc_state_t;
endpackage
`default_nettype wire

// *** verilog/dpc_profile_coeff_ram.sv ***
// Serial-programmed profile and coefficient store of one demodulator subchip.
// Assumes core_clk is the running sample clock and serial pins are asynchronous.
// What this block does and what it needs from the host
// [RL1] Host rewrites the profile selector after loading either memory.
// [RL2] New profile, coefficient and selector settings apply only on a trigger; coefficient blocks are read from memory at each fetch without one.
// [RL3] Host keeps the sample clock running during any programming.
// [RL4] Profile memory holds 32 entries of 64 bits.
// [RL5] Profile write pointer is loaded through the broadcast address first.
// [RL6] Entry carries pointer 35:28, decimation 27:22, frequency 21:6.
// [RL7] Bits 4:2 hold gain; reserved bits written zero; bits 1:0 ignored.
// [RL8] Coefficients fetched from block P times eight across M blocks.
// [RL9] Host lowers both enables, writes entries MSB first, raises enables.
// [RL10] Profile write pointer advances after each complete 64-bit entry.
// [RL11] Active profile index sits in selector bits 15:11, broadcast.
// [RL12] Coefficient memory holds 256 blocks of 112 bits.
// [RL13] Host loads the coefficient write pointer before writing blocks.
// [RL14] Blocks shift MSB first; tap 0 in bits 13:0, tap 7 in 111:98.
// [RL15] Every stored tap is a 14-bit two's complement value.
// [RL16] Symmetric filter has 16 times M taps from 8 times M stored.
// [RL17] Tap I of block j is coefficient M*(1+I)-(1+j).
// [RL18] Manual fields may replace pointer, decimation, frequency and gain.
// [RL19] Host should program both memories before other registers.
// [RL20] Neither memory is cleared by reset; host writes all entries.
`timescale 1ns/1ps
`default_nettype none
`include "dpc_map.svh"
module dpc_profile_coeff_ram #(
   parameter int SUBCHIP_ID = 0
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic serial_clk,
   input wire logic serial_data,
   input wire logic serial_enable_n,
   input wire logic digital_block_serial_enable_n,
   input wire logic tx_sync_in,
   input wire logic fetch_req,
   input wire logic [4:0] fetch_phase,
   output dpc_pkg::dpc_cfg_t active_cfg,
   output logic [9:0] filter_tap_count,
   output dpc_pkg::dpc_block_t coeff_block,
   output dpc_pkg::dpc_index_t coeff_index,
   output logic coeff_valid,
   output logic [7:0] coeff_write_ptr,
   output logic [4:0] profile_write_ptr
);
   // Only two subchip select bits exist in the address byte
   if (SUBCHIP_ID < 0 || SUBCHIP_ID > 1)
   begin : g_bad_subchip
      $error("SUBCHIP_ID must be 0 or 1");
   end

   function automatic logic [6:0] word_len(input logic [5:0] reg_addr);
      if (reg_addr == `DPC_REG_COEFF_DATA)
         return `DPC_LEN_COEFF;
      else if (reg_addr == `DPC_REG_PROF_DATA)
         return `DPC_LEN_PROF;
      else
         return `DPC_LEN_REG;
   endfunction

   // Tap position within a block to filter coefficient number
   function automatic logic [7:0] tap_number(input logic [5:0] m, input logic [2:0] i,
                                             input logic [4:0] j);
      logic [9:0] prod;
      prod = 10'(m) * (10'(i) + 10'h001);
      return 8'(prod - (10'(j) + 10'h001));
   endfunction

   // Pin synchronisers; first stages feed only second stages
   logic [2:0] sclk_q;
   logic [1:0] sdat_q;
   logic [1:0] sen_q;
   logic [1:0] dig_q;
   logic [2:0] sync_q;
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         sclk_q <= 3'h0;
         sdat_q <= 2'h0;
         sen_q <= 2'h3;
         dig_q <= 2'h3;
         sync_q <= 3'h0;
      end
      else
      begin
         sclk_q <= {sclk_q[1:0], serial_clk};
         sdat_q <= {sdat_q[0], serial_data};
         sen_q <= {sen_q[0], serial_enable_n};
         dig_q <= {dig_q[0], digital_block_serial_enable_n};
         sync_q <= {sync_q[1:0], tx_sync_in};
      end
   end

   logic sclk_rise;
   logic frame;
   logic tx_rise;
   assign sclk_rise = sclk_q[1] & ~sclk_q[2];
   assign frame = ~sen_q[1];
   assign tx_rise = sync_q[1] & ~sync_q[2];

   // Serial frame: 8 address bits then back-to-back words of the addressed width
   dpc_pkg::dpc_state_t state_q;
   logic [6:0] bit_cnt_q;
   logic [7:0] addr_q;
   logic [111:0] shift_q;
   logic [111:0] shift_d;
   logic wr_q;
   logic [5:0] wr_reg_q;
   logic [111:0] wr_word_q;
   logic addr_ok;
   assign shift_d = {shift_q[110:0], sdat_q[1]};
   // Only words addressed to this subchip and sent with the digital enable low count
   assign addr_ok = addr_q[6 + SUBCHIP_ID] & ~dig_q[1];

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         state_q <= dpc_pkg::DPC_IDLE;
         bit_cnt_q <= 7'h00;
         addr_q <= 8'h00;
         shift_q <= 112'h0;
         wr_q <= 1'b0;
         wr_reg_q <= 6'h00;
         wr_word_q <= 112'h0;
      end
      else
      begin
         wr_q <= 1'b0;
         if (!frame)
         begin
            state_q <= dpc_pkg::DPC_IDLE;
            bit_cnt_q <= 7'h00;
         end
         else
         begin
            unique case (state_q)
               dpc_pkg::DPC_IDLE:
               begin
                  state_q <= dpc_pkg::DPC_ADDR;
                  bit_cnt_q <= 7'h00;
               end
               dpc_pkg::DPC_ADDR:
               begin
                  if (sclk_rise)
                  begin
                     addr_q <= {addr_q[6:0], sdat_q[1]};
                     bit_cnt_q <= bit_cnt_q + 7'h01;
                     if (bit_cnt_q == `DPC_ADDR_LAST)
                     begin
                        state_q <= dpc_pkg::DPC_DATA;
                        bit_cnt_q <= 7'h00;
                     end
                  end
               end
               dpc_pkg::DPC_DATA:
               begin
                  if (sclk_rise)
                  begin
                     shift_q <= shift_d;
                     bit_cnt_q <= bit_cnt_q + 7'h01;
                     // Entries arrive MSB first, so the last bit lands in bit 0
                     if (bit_cnt_q == word_len(addr_q[5:0]) - 7'h01) // RL9 RL14
                     begin
                        bit_cnt_q <= 7'h00;
                        wr_q <= addr_ok; // RL5 RL11
                        wr_reg_q <= addr_q[5:0];
                        wr_word_q <= shift_d;
                     end
                  end
               end
               default:
                  state_q <= dpc_pkg::DPC_IDLE;
            endcase
         end
      end
   end

   function automatic logic hit(input logic [5:0] reg_addr);
      return wr_q && wr_reg_q == reg_addr;
   endfunction

   // Control registers
   logic [7:0] coeff_ptr_q;
   logic [4:0] prof_ptr_q;
   logic [15:0] sel_q;
   logic [15:0] man_start_q;
   logic [15:0] dec_shift_q;
   logic [15:0] freq_en_q;
   logic [15:0] freq_q;
   logic man_trig_q;
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         coeff_ptr_q <= 8'h00;
         prof_ptr_q <= 5'h00;
         sel_q <= `DPC_REG_RESET;
         man_start_q <= `DPC_REG_RESET;
         dec_shift_q <= `DPC_REG_RESET;
         freq_en_q <= `DPC_REG_RESET;
         freq_q <= `DPC_REG_RESET;
         man_trig_q <= 1'b0;
      end
      else
      begin
         man_trig_q <= hit(`DPC_REG_TRIG) && wr_word_q[`DPC_TRIG_BIT]; // RL2
         if (hit(`DPC_REG_COEFF_PTR))
            coeff_ptr_q <= wr_word_q[7:0]; // RL13
         else if (hit(`DPC_REG_COEFF_DATA))
            coeff_ptr_q <= coeff_ptr_q + 8'h01; // RL14
         if (hit(`DPC_REG_PROF_PTR))
            prof_ptr_q <= wr_word_q[4:0]; // RL5
         else if (hit(`DPC_REG_PROF_DATA))
            prof_ptr_q <= prof_ptr_q + 5'h01; // RL10
         if (hit(`DPC_REG_PROF_SEL))
            sel_q <= wr_word_q[15:0]; // RL11
         if (hit(`DPC_REG_MAN_START))
            man_start_q <= wr_word_q[15:0]; // RL18
         if (hit(`DPC_REG_DEC_SHIFT))
            dec_shift_q <= wr_word_q[15:0];
         if (hit(`DPC_REG_MAN_FREQ_EN))
            freq_en_q <= wr_word_q[15:0];
         if (hit(`DPC_REG_MAN_FREQ))
            freq_q <= wr_word_q[15:0];
      end
   end

   // Storage has no reset and no initial contents
   logic [63:0] prof_mem [32]; // RL4 RL20
   logic [111:0] coeff_mem [256]; // RL12 RL20
   always_ff @(posedge core_clk)
   begin
      if (hit(`DPC_REG_PROF_DATA))
         prof_mem[prof_ptr_q] <= wr_word_q[63:0]; // RL4
      if (hit(`DPC_REG_COEFF_DATA))
         coeff_mem[coeff_ptr_q] <= wr_word_q; // RL12
   end

   // Active profile is only taken up on a trigger, so a half-written set never leaks
   logic trig;
   logic [63:0] entry;
   dpc_pkg::dpc_cfg_t act_q;
   assign trig = tx_rise | man_trig_q; // RL2
   assign entry = prof_mem[sel_q[`DPC_SEL_IDX]]; // RL11
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         act_q <= '0;
      else if (trig)
      begin
         act_q.coeff_start <= man_start_q[`DPC_MS_EN] ? man_start_q[`DPC_MS_START]
                                                      : entry[`DPC_PF_PTR]; // RL6 RL18
         act_q.dec_factor <= man_start_q[`DPC_MD_EN] ? man_start_q[`DPC_MD_DEC]
                                                     : entry[`DPC_PF_DEC]; // RL6 RL18
         act_q.freq <= freq_en_q[`DPC_MF_EN] ? freq_q : entry[`DPC_PF_FREQ]; // RL6 RL18
         // Bits 1:0 and reserved bits are never looked at
         act_q.gain <= dec_shift_q[`DPC_SH_EN] ? dec_shift_q[`DPC_SH_GAIN]
                                               : entry[`DPC_PF_GAIN]; // RL7 RL18
      end
   end

   // Coefficient fetch; P times eight wraps within the 256 blocks
   logic [7:0] fetch_addr;
   logic [7:0] coeff_addr_q;
   dpc_pkg::dpc_block_t block_q;
   dpc_pkg::dpc_index_t index_q;
   logic valid_q;
   assign fetch_addr = {act_q.coeff_start[4:0], 3'h0} + {3'h0, fetch_phase}; // RL8
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         coeff_addr_q <= 8'h00;
         block_q <= '0;
         index_q <= '0;
         valid_q <= 1'b0;
      end
      else
      begin
         valid_q <= fetch_req;
         if (fetch_req)
         begin
            coeff_addr_q <= fetch_addr; // RL8
            block_q <= coeff_mem[fetch_addr]; // RL15 RL16
            for (int i = 0; i < 8; i++)
               index_q[i] <= tap_number(act_q.dec_factor, 3'(i), fetch_phase); // RL17
         end
      end
   end

   assign active_cfg = act_q;
   assign filter_tap_count = {act_q.dec_factor, 4'h0}; // RL16
   assign coeff_block = block_q;
   assign coeff_index = index_q;
   assign coeff_valid = valid_q;
   assign coeff_write_ptr = coeff_ptr_q;
   assign profile_write_ptr = prof_ptr_q;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   prof_ptr_step_a: assert property ( // RL10
      hit(`DPC_REG_PROF_DATA) |=> prof_ptr_q == $past(prof_ptr_q) + 5'h01)
      else $error("profile pointer did not advance");
   prof_store_a: assert property ( // RL4
      hit(`DPC_REG_PROF_DATA) |=> prof_mem[$past(prof_ptr_q)] == $past(wr_word_q[63:0]))
      else $error("profile entry not stored");
   coeff_store_a: assert property ( // RL12
      hit(`DPC_REG_COEFF_DATA) |=> coeff_mem[$past(coeff_ptr_q)] == $past(wr_word_q)
         && coeff_ptr_q == $past(coeff_ptr_q) + 8'h01)
      else $error("coefficient block not stored");
   cfg_hold_a: assert property (!trig |=> act_q == $past(act_q)) // RL2
      else $error("active profile changed without trigger");
   man_start_a: assert property ( // RL18
      trig && man_start_q[`DPC_MS_EN]
         |=> act_q.coeff_start == $past(man_start_q[`DPC_MS_START]))
      else $error("manual start address not applied");
   prof_take_a: assert property ( // RL6
      trig && !man_start_q[`DPC_MD_EN]
         |=> act_q.dec_factor == $past(entry[`DPC_PF_DEC]))
      else $error("decimation factor not taken from entry");
   fetch_addr_a: assert property ( // RL8
      fetch_req |=> coeff_valid
         && coeff_addr_q == 8'($past(act_q.coeff_start) * 8 + $past(fetch_phase)))
      else $error("wrong coefficient block fetched");
   tap_index_a: assert property ( // RL17
      fetch_req |=> coeff_index[7] == 8'($past(act_q.dec_factor) * 8 - 1 - $past(fetch_phase)))
      else $error("tap index wrong");
   write_gate_a: assert property (wr_q |-> $past(frame) && addr_q[6 + SUBCHIP_ID]) // RL11
      else $error("write outside frame or to other subchip");
endmodule
`default_nettype wire

// *** testbench/dpc_host_model.sv ***
// Host controller model driving the serial configuration pins of the store.
// Assumes core_clk runs throughout and the bench calls write_frame.
`timescale 1ns/1ps
`default_nettype none
module dpc_host_model (
   input wire logic core_clk,
   output logic serial_clk,
   output logic serial_data,
   output logic serial_enable_n,
   output logic digital_block_serial_enable_n
);
   initial
   begin
      serial_clk = 1'b0;
      serial_data = 1'b0;
      serial_enable_n = 1'b1;
      digital_block_serial_enable_n = 1'b1;
   end
   // Four core cycles a phase keeps clear of the three-cycle minimum
   task automatic send_bit(input logic b);
      serial_data = b;
      repeat (4) @(posedge core_clk);
      #1 serial_clk = 1'b1;
      repeat (4) @(posedge core_clk);
      #1 serial_clk = 1'b0;
   endtask
   // Address then word, MSB first; dig_n high makes the device drop the word
   task automatic write_frame(input logic [7:0] addr, input logic [111:0] word,
      input int len, input logic dig_n);
      int i;
      @(posedge core_clk);
      #1 serial_enable_n = 1'b0;
      digital_block_serial_enable_n = dig_n;
      repeat (4) @(posedge core_clk);
      #1;
      for (i = 7; i >= 0; i--)
         send_bit(addr[i]);
      for (i = len - 1; i >= 0; i--)
         send_bit(word[i]);
      repeat (4) @(posedge core_clk);
      #1 serial_enable_n = 1'b1;
      digital_block_serial_enable_n = 1'b1;
      // A released data line must not keep showing its last bit
      serial_data = ~serial_data;
   endtask
endmodule
`default_nettype wire

// *** testbench/dpc_profile_coeff_ram_tb.sv ***
// Self-checking bench for the profile and coefficient store of subchip 0.
// Assumes the host model drives the serial pins and core_clk never stops.
`timescale 1ns/1ps
`default_nettype none
module dpc_profile_coeff_ram_tb;
   typedef struct {
      logic [4:0] idx;
      logic [7:0] p;
      logic [5:0] m;
      logic [15:0] f;
      logic [2:0] g;
      logic [4:0] j;
      logic [9:0] taps;
   } dpc_row_t;
   dpc_row_t rows [4] = '{
      '{5'h00, 8'h00, 6'h01, 16'h1234, 3'h0, 5'h00, 10'h010},
      '{5'h05, 8'h11, 6'h04, 16'hfedc, 3'h7, 5'h03, 10'h040},
      '{5'h0c, 8'h1f, 6'h02, 16'h8001, 3'h3, 5'h01, 10'h020},
      '{5'h1f, 8'hff, 6'h20, 16'h0000, 3'h5, 5'h07, 10'h200}};
   logic core_clk, rst, serial_clk, serial_data, serial_enable_n;
   logic digital_block_serial_enable_n, tx_sync_in, fetch_req, coeff_valid;
   logic [4:0] fetch_phase, profile_write_ptr;
   logic [7:0] coeff_write_ptr, addr;
   logic [9:0] filter_tap_count;
   dpc_pkg::dpc_cfg_t active_cfg, cfg;
   dpc_pkg::dpc_block_t coeff_block;
   dpc_pkg::dpc_index_t coeff_index;
   dpc_row_t r;
   int num_errors, samples_checked;

   dpc_host_model host_u (.core_clk(core_clk), .serial_clk(serial_clk),
      .serial_data(serial_data), .serial_enable_n(serial_enable_n),
      .digital_block_serial_enable_n(digital_block_serial_enable_n));
   dpc_profile_coeff_ram #(.SUBCHIP_ID(0)) dut_u (.core_clk(core_clk), .rst(rst),
      .serial_clk(serial_clk), .serial_data(serial_data),
      .serial_enable_n(serial_enable_n),
      .digital_block_serial_enable_n(digital_block_serial_enable_n),
      .tx_sync_in(tx_sync_in), .fetch_req(fetch_req), .fetch_phase(fetch_phase),
      .active_cfg(active_cfg), .filter_tap_count(filter_tap_count),
      .coeff_block(coeff_block), .coeff_index(coeff_index), .coeff_valid(coeff_valid),
      .coeff_write_ptr(coeff_write_ptr), .profile_write_ptr(profile_write_ptr));

   initial
   begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   task automatic chk(input logic [127:0] got, input logic [127:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Strobe lands about three cycles after the last serial clock rise, inside the frame; eight leaves margin
   task automatic wr(input logic [7:0] a, input logic [111:0] w, input int len);
      host_u.write_frame(a, w, len, 1'b0);
      repeat (8) @(posedge core_clk);
      #1;
   endtask
   function automatic dpc_pkg::dpc_block_t mk_blk(input logic [4:0] idx);
      for (int i = 0; i < 8; i++)
         mk_blk[i] = {1'b1, idx, 8'(i * 17)};
   endfunction
   function automatic dpc_pkg::dpc_cfg_t mk_cfg(input dpc_row_t x);
      mk_cfg = '{x.p, x.m, x.f, x.g};
   endfunction
   task automatic fetch(input logic [4:0] j, input dpc_pkg::dpc_block_t blk,
      input logic [5:0] m);
      dpc_pkg::dpc_index_t ix;
      for (int i = 0; i < 8; i++)
         ix[i] = 8'(m * (1 + i) - (1 + j));
      fetch_phase = j;
      fetch_req = 1'b1;
      @(posedge core_clk);
      #1 fetch_req = 1'b0;
      chk(coeff_valid, 1'b1);
      chk(coeff_block, blk);
      chk(coeff_index, ix);
      @(posedge core_clk);
      #1 chk(coeff_valid, 1'b0);
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial
   begin
      repeat (40000) @(posedge core_clk);
      num_errors++;
      stop_test();
   end

   initial
   begin
      rst = 1'b1;
      tx_sync_in = 1'b0;
      fetch_req = 1'b0;
      fetch_phase = 5'h00;
      num_errors = 0;
      samples_checked = 0;
      repeat (12) @(posedge core_clk);
      #1 rst = 1'b0;
      chk(active_cfg, 33'h0);
      chk({coeff_valid, coeff_write_ptr, profile_write_ptr}, 14'h0);
      $display("test reset done");
      foreach (rows[k])
      begin
         r = rows[k];
         addr = 8'({r.p, 3'b000} + r.j);
         wr(8'hc8, 112'(r.idx), 16);
         wr(8'hc9, {28'h0, r.p, r.m, r.f, 1'b0, r.g, 2'b11}, 64);
         chk(profile_write_ptr, 5'(r.idx + 5'h01));
         wr(8'hc6, 112'(addr), 16);
         wr(8'hc7, mk_blk(r.idx), 112);
         chk(coeff_write_ptr, 8'(addr + 8'h01));
         wr(8'hce, 112'({r.idx, 11'h000}), 16);
         wr(8'hc0, 112'h4, 16);
         cfg = mk_cfg(r);
         chk(active_cfg, cfg);
         chk(filter_tap_count, r.taps);
         fetch(r.j, mk_blk(r.idx), r.m);
         $display("test row %0d done", k);
      end
      // Selector alone must wait for the sync pin
      wr(8'hce, 112'h0, 16);
      chk(active_cfg, cfg);
      tx_sync_in = 1'b1;
      repeat (3) @(posedge core_clk);
      #1 tx_sync_in = 1'b0;
      repeat (8) @(posedge core_clk);
      #1 chk(active_cfg, mk_cfg(rows[0]));
      $display("test sync trigger done");
      wr(8'h88, 112'h3, 16);
      host_u.write_frame(8'hc8, 112'h3, 16, 1'b1);
      repeat (8) @(posedge core_clk);
      #1 chk(profile_write_ptr, 5'h00);
      $display("test refused writes done");
      wr(8'hdf, 112'ha100, 16);
      wr(8'hc0, 112'h4, 16);
      cfg = mk_cfg(rows[0]);
      cfg.coeff_start = 8'h42;
      chk(active_cfg, cfg);
      // Every manual override at once: start pointer, decimation, gain and frequency
      wr(8'hdf, 112'ha145, 16);
      wr(8'hdd, 112'he0, 16);
      wr(8'he0, 112'h1, 16);
      wr(8'he1, 112'h5a5a, 16);
      wr(8'hc0, 112'h4, 16);
      cfg = '{8'h42, 6'h05, 16'h5a5a, 3'h6};
      chk(active_cfg, cfg);
      chk(filter_tap_count, 10'h050);
      $display("test manual start done");
      rst = 1'b1;
      @(posedge core_clk);
      #1 chk(active_cfg, 33'h0);
      rst = 1'b0;
      wr(8'hce, 112'h0, 16);
      wr(8'hc0, 112'h4, 16);
      chk(active_cfg, mk_cfg(rows[0]));
      fetch(5'h00, mk_blk(5'h00), 6'h01);
      $display("test memory kept over reset done");
      stop_test();
   end
endmodule
`default_nettype wire
